// ==== rtl/accum_datapath.sv ====
// accum_datapath: 4-bit accumulator datapath with table lookup and skips
// assumes: sequencer hands one instruction per valid/ready handshake, owns
// the stack; rom answers a request with rom_valid; memory is same-clock
//
// Operation
// - load immediate writes operand into accumulator
// - back-to-back loads: only first one executes
// - lookup word bits 7:4 to b, 3:0 to acc
// - lookup address is d[2:0] above accumulator
// - upper flag set: rom 9:8 to d, d2 cleared
// - lookup pushes then restores one stack level
// - add memory into accumulator, carry kept
// - add with carry updates accumulator and carry
// - add immediate into accumulator, carry kept
// - add immediate skips next unless it overflowed
// - and memory nibble into accumulator
// - or memory nibble into accumulator
// - set carry forces carry to one
// - clear carry forces carry to zero
// - carry test skips next when carry zero
// - complement inverts the accumulator
// - lookup page is instruction bits 5:0, pages 0 to 63 for either rom variant
`timescale 1ns/1ps
`default_nettype none
module accum_datapath
  import accum_pkg::*;
#(
  parameter int unsigned PAGE_COUNT = 64 // 64 small rom, 96 large rom
)(
  input  wire logic        clk,
  input  wire logic        rst,
  // instruction stream from the sequencer
  input  wire logic        instr_valid,
  output logic             instr_ready,
  input  wire logic [9:0]  instr_code,
  output logic             skip_next,
  output logic             stack_push,
  output logic             stack_pop,
  // data memory at the data pointer
  input  wire logic [3:0]  pointed_memory_nibble,
  // program rom
  output logic             rom_req,
  output logic [6:0]       rom_page,
  output logic [6:0]       rom_addr,
  input  wire logic        rom_valid,
  input  wire logic [9:0]  rom_data,
  // axi4-lite slave
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [3:0]    acc_reg;    // accumulator
  logic [3:0]    b_reg;      // register b
  logic [2:0]    d_reg;      // table_high_address_bits
  logic          carry_reg;  // carry_flag
  logic          table_upper_bits_flag_reg;   // table_upper_bits_flag
  logic          skip_reg;   // next instruction is to be skipped
  logic          la_prev_reg;// last accepted instruction was a load
  logic          push_reg;   // one-cycle stack push
  lookup_state_t state_reg;  // lookup sequence
  op_t           op;         // decoded current instruction
  logic          accept;     // instruction handshake
  logic          suppress;   // fetched but without effect
  logic          exec;       // instruction takes effect
  logic [3:0]    alu_result; // alu output
  logic          alu_carry;  // carry out of bit 3
  logic [3:0]    alu_operand;// immediate or memory nibble
  logic          wr_go;      // register write taken
  logic          rd_go;      // register read taken

  assign op          = decode_op(instr_code);
  assign instr_ready = (state_reg == ST_IDLE);
  assign accept      = instr_valid && instr_ready;
  assign suppress    = skip_reg || (op == OP_LOAD_IMM && la_prev_reg);
  assign exec        = accept && !suppress;
  assign skip_next   = skip_reg;
  assign stack_push  = push_reg;
  assign stack_pop   = (state_reg == ST_RESTORE);
  assign rom_req     = (state_reg == ST_FETCH);
  assign alu_operand = (op == OP_ADD_IMM) ? instr_code[3:0]
                                          : pointed_memory_nibble;

  // shared arithmetic and logic unit
  nibble_alu u_alu (
    .a         (acc_reg),
    .operand   (alu_operand),
    .carry_in  (carry_reg && op == OP_ADD_MEMC),
    .op        (op),
    .result    (alu_result),
    .carry_out (alu_carry)
  );

  // ----------------------------------------------------------------------
  // accumulator and register b
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      acc_reg <= ACC_RESET;
      b_reg   <= ACC_RESET;
    end else if (exec) begin
      case (op)
        OP_LOAD_IMM: acc_reg <= instr_code[3:0];
        OP_ADD_MEM:  acc_reg <= alu_result;
        OP_ADD_MEMC: acc_reg <= alu_result;
        OP_ADD_IMM:  acc_reg <= alu_result;
        OP_AND:      acc_reg <= alu_result;
        OP_OR:       acc_reg <= alu_result;
        OP_CMA:      acc_reg <= alu_result;
        default:     acc_reg <= acc_reg;         // others leave it
      endcase
    end else if (state_reg == ST_FETCH && rom_valid) begin
      b_reg   <= rom_data[7:4];
      acc_reg <= rom_data[3:0];
    end
  end

  // ----------------------------------------------------------------------
  // carry flag
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      carry_reg <= 1'b0;
    end else if (exec) begin
      case (op)
        OP_ADD_MEMC: carry_reg <= alu_carry;
        OP_SET_CY:   carry_reg <= 1'b1;
        OP_CLR_CY:   carry_reg <= 1'b0;
        default:     carry_reg <= carry_reg; // add memory, add immediate and test keep it
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // skip control
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      skip_reg    <= 1'b0;
      la_prev_reg <= 1'b0;
    end else if (accept) begin
      // a run of loads counts skipped ones too
      la_prev_reg <= (op == OP_LOAD_IMM);
      skip_reg    <= exec &&
                     ((op == OP_ADD_IMM && !alu_carry) ||
                      (op == OP_SKIP_NC && !carry_reg));
    end
  end

  // ----------------------------------------------------------------------
  // table lookup sequence
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      push_reg  <= 1'b0;
      rom_page  <= 7'h00;
      rom_addr  <= 7'h00;
    end else begin
      push_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (exec && op == OP_TABLE) begin
            push_reg  <= 1'b1;
            rom_page  <= {1'b0, instr_code[5:0]};
            rom_addr  <= {d_reg, acc_reg};
            state_reg <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          if (rom_valid) state_reg <= ST_RESTORE;
        end
        ST_RESTORE: state_reg <= ST_IDLE;         // pop then resume
        default:    state_reg <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // register d and upper flag
  // ----------------------------------------------------------------------
  // register d: a lookup's rom bits win over a bus write in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      d_reg <= D_RESET;
    end else if (state_reg == ST_FETCH && rom_valid && table_upper_bits_flag_reg) begin
      d_reg <= {1'b0, rom_data[9:8]};
    end else if (wr_go && s_axi_wstrb[0] &&
                 s_axi_awaddr == ADDR_TABLE_HIGH) begin
      d_reg <= s_axi_wdata[2:0];
    end
  end

  // upper flag: software only, so a finishing lookup never drops a write
  always_ff @(posedge clk) begin
    if (rst) begin
      table_upper_bits_flag_reg <= TABLE_UPPER_BITS_FLAG_RESET;
    end else if (wr_go && s_axi_wstrb[0] && s_axi_awaddr == ADDR_CTRL) begin
      table_upper_bits_flag_reg <= s_axi_wdata[0];
    end
  end

  // ----------------------------------------------------------------------
  // axi4-lite write channel: address and data taken together
  // ----------------------------------------------------------------------
  assign wr_go         = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;

  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (s_axi_awaddr == ADDR_CTRL ||
                       s_axi_awaddr == ADDR_TABLE_HIGH) ? RESP_OKAY
                                                        : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------------
  assign rd_go         = s_axi_arvalid && !s_axi_rvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      s_axi_rdata  <= 32'h0000_0000;
      case (s_axi_araddr)
        ADDR_CTRL:       s_axi_rdata[0] <= table_upper_bits_flag_reg;
        ADDR_TABLE_HIGH: s_axi_rdata[2:0] <= d_reg;
        ADDR_STATE: begin
          s_axi_rdata[ST_ACC_LSB +: 4] <= acc_reg;
          s_axi_rdata[ST_CARRY_BIT]    <= carry_reg;
          s_axi_rdata[ST_B_LSB +: 4]   <= b_reg;
          s_axi_rdata[ST_D_LSB +: 3]   <= d_reg;
          s_axi_rdata[ST_SKIP_BIT]     <= skip_reg;
          s_axi_rdata[ST_BUSY_BIT]     <= (state_reg != ST_IDLE);
        end
        default: s_axi_rresp <= RESP_SLVERR; // unmapped
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  logic [4:0] chk_sum; // independent five-bit reference sum
  assign chk_sum = {1'b0, acc_reg} + {1'b0, pointed_memory_nibble}
                 + {4'h0, carry_reg};

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_load_value: assert property (exec && op == OP_LOAD_IMM |=>
    acc_reg == $past(instr_code[3:0])) else $error("load value wrong");
  a_load_chain: assert property (accept && op == OP_LOAD_IMM
    && la_prev_reg |=> acc_reg == $past(acc_reg))
    else $error("chained load executed");
  a_lookup_split: assert property (rom_req && rom_valid |=>
    b_reg == $past(rom_data[7:4]) && acc_reg == $past(rom_data[3:0]))
    else $error("lookup split wrong");
  a_lookup_addr: assert property (push_reg |->
    rom_addr == {$past(d_reg), $past(acc_reg)})
    else $error("lookup address wrong");
  a_upper_bits: assert property (rom_req && rom_valid && table_upper_bits_flag_reg
    |=> d_reg == {1'b0, $past(rom_data[9:8])})
    else $error("upper bits not loaded");
  a_stack_pair: assert property (rom_req && rom_valid |=>
    stack_pop && !rom_req ##1 !stack_pop && instr_ready)
    else $error("stack level not restored");
  a_push_fetch: assert property (push_reg |->
    rom_req && !instr_ready && !stack_pop)
    else $error("push without fetch");
  a_add_mem: assert property (exec && op == OP_ADD_MEM |=>
    acc_reg == 4'($past(acc_reg) + $past(pointed_memory_nibble))
    && $stable(carry_reg)) else $error("add memory wrong");
  a_add_carry: assert property (exec && op == OP_ADD_MEMC |=>
    {carry_reg, acc_reg} == $past(chk_sum))
    else $error("add with carry wrong");
  a_addi_skip: assert property (exec && op == OP_ADD_IMM |=>
    skip_next == !$past(alu_carry) && $stable(carry_reg))
    else $error("add immediate skip wrong");
  a_logic_ops: assert property (exec && op == OP_OR |=>
    acc_reg == ($past(acc_reg) | $past(pointed_memory_nibble)))
    else $error("or result wrong");
  a_carry_set: assert property (exec && op == OP_SET_CY |=>
    carry_reg && $stable(acc_reg)) else $error("carry not set");
  a_carry_test: assert property (exec && op == OP_SKIP_NC |=>
    skip_next == !carry_reg && $stable(carry_reg))
    else $error("carry test wrong");
  a_skip_effect: assert property (accept && skip_reg |=>
    $stable(acc_reg) && $stable(carry_reg) && !skip_next)
    else $error("skipped op took effect");
  a_page_range: assert property (rom_req |->
    rom_page < PAGE_COUNT) else $error("page out of range");

  c_lookup: cover property (push_reg ##[1:20] stack_pop);
  c_addi_skip: cover property (exec && op == OP_ADD_IMM ##1 accept);
  c_load_chain: cover property (accept && op == OP_LOAD_IMM
    && la_prev_reg);

endmodule : accum_datapath
`default_nettype wire

// ==== rtl/accum_pkg.sv ====
// accum_pkg: opcodes, register map and field layout of the nibble datapath
// assumes: 10-bit instruction words, 4-bit data memory, AXI4-Lite 32-bit
package accum_pkg;

  // ----------------------------------------------------------------------
  // instruction encodings
  // ----------------------------------------------------------------------
  localparam logic [9:0] OPC_ADD_MEM   = 10'h00A; // add_memory
  localparam logic [9:0] OPC_ADD_MEMC  = 10'h00B; // add_memory_with_carry
  localparam logic [9:0] OPC_AND       = 10'h018; // and with memory
  localparam logic [9:0] OPC_OR        = 10'h019; // or with memory
  localparam logic [9:0] OPC_SET_CY    = 10'h007; // set_carry
  localparam logic [9:0] OPC_CLR_CY    = 10'h006; // clear_carry_op
  localparam logic [9:0] OPC_SKIP_NC   = 10'h02F; // skip_if_carry_clear
  localparam logic [9:0] OPC_CMA       = 10'h01C; // complement_accumulator
  localparam logic [5:0] OPC_LOAD_HI   = 6'h07;   // load_immediate, code[9:4]
  localparam logic [5:0] OPC_ADDI_HI   = 6'h06;   // add immediate, code[9:4]
  localparam logic [3:0] OPC_TABLE_HI  = 4'h2;    // table_lookup_call, [9:6]

  // ----------------------------------------------------------------------
  // register map (byte addresses) and fields
  // ----------------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL       = 4'h0; // bit0 table_upper_bits_flag
  localparam logic [3:0] ADDR_TABLE_HIGH = 4'h4; // bits 2:0 register d
  localparam logic [3:0] ADDR_STATE      = 4'h8; // read-only datapath state
  localparam int unsigned ST_ACC_LSB   = 0;
  localparam int unsigned ST_CARRY_BIT = 4;
  localparam int unsigned ST_B_LSB     = 8;
  localparam int unsigned ST_D_LSB     = 12;
  localparam int unsigned ST_SKIP_BIT  = 16;
  localparam int unsigned ST_BUSY_BIT  = 17;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [3:0] ACC_RESET  = 4'h0;
  localparam logic [2:0] D_RESET    = 3'h0;
  localparam logic       TABLE_UPPER_BITS_FLAG_RESET = 1'b0;

  // decoded operations
  typedef enum logic [3:0] {
    OP_NONE, OP_LOAD_IMM, OP_TABLE, OP_ADD_MEM, OP_ADD_MEMC, OP_ADD_IMM,
    OP_AND, OP_OR, OP_SET_CY, OP_CLR_CY, OP_SKIP_NC, OP_CMA
  } op_t;

  // table lookup sequence, gray along idle -> fetch -> restore
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_FETCH   = 2'b01,
    ST_RESTORE = 2'b11
  } lookup_state_t;

  // instruction word to operation
  function automatic op_t decode_op(input logic [9:0] code);
    op_t op;
    op = OP_NONE;
    if (code[9:4] == OPC_LOAD_HI)       op = OP_LOAD_IMM;
    else if (code[9:4] == OPC_ADDI_HI)  op = OP_ADD_IMM;
    else if (code[9:6] == OPC_TABLE_HI) op = OP_TABLE;
    else begin
      case (code)
        OPC_ADD_MEM:  op = OP_ADD_MEM;
        OPC_ADD_MEMC: op = OP_ADD_MEMC;
        OPC_AND:      op = OP_AND;
        OPC_OR:       op = OP_OR;
        OPC_SET_CY:   op = OP_SET_CY;
        OPC_CLR_CY:   op = OP_CLR_CY;
        OPC_SKIP_NC:  op = OP_SKIP_NC;
        OPC_CMA:      op = OP_CMA;
        default:      op = OP_NONE;
      endcase
    end
    return op;
  endfunction : decode_op

endpackage : accum_pkg

// ==== rtl/nibble_alu.sv ====
// nibble_alu: combinational 4-bit add / and / or / complement unit
// assumes: operands stable within the cycle, op from accum_pkg::op_t
`timescale 1ns/1ps
`default_nettype none
module nibble_alu
  import accum_pkg::*;
(
  input  wire logic [3:0] a,        // accumulator
  input  wire logic [3:0] operand,  // memory nibble or immediate
  input  wire logic       carry_in, // carry flag for add with carry
  input  wire op_t        op,       // decoded operation
  output logic      [3:0] result,   // 4-bit result
  output logic            carry_out // carry out of bit 3
);

  logic [4:0] sum; // five-bit sum keeps the carry

  // ----------------------------------------------------------------------
  // operation select
  // ----------------------------------------------------------------------
  always_comb begin
    sum = {1'b0, a} + {1'b0, operand} + {4'h0, carry_in};
    carry_out = sum[4];
    case (op)
      OP_AND:  result = a & operand;
      OP_OR:   result = a | operand;
      OP_CMA:  result = ~a;
      default: result = sum[3:0]; // all add forms
    endcase
  end

endmodule : nibble_alu
`default_nettype wire

// ==== tb/accumulator_alu_table_lookup_tb_top.sv ====
// accumulator_alu_table_lookup_tb_top: self-checking bench of the datapath
// assumes: far_side_model plays rom and stack, bench plays sequencer and bus
`timescale 1ns/1ps
`default_nettype none
module accumulator_alu_table_lookup_tb_top;
  import accum_pkg::*;
  // ----------------------------------------------------------------------
  // signals and case table
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [3:0] a0;   // accumulator preset
    logic       cy;   // carry preset
    logic [9:0] code; // instruction under test
    logic [3:0] mem;  // pointed memory nibble
    logic [3:0] acc;  // expected accumulator
    logic       cyo;  // expected carry
    logic       skp;  // expected skip
  } row_t;
  logic        clk, rst, instr_valid, instr_ready, skip_next;
  logic        stack_push, stack_pop, rom_req, rom_valid;
  logic [9:0]  instr_code, rom_data;
  logic [6:0]  rom_page, rom_addr;
  logic [3:0]  pointed_memory_nibble, s_axi_awaddr, s_axi_araddr;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, st;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  int          rom_delay, depth, max_depth, error_cnt, tests_run;
  row_t        r;
  row_t        rows [13] = '{
    '{4'h5, 1'b1, OPC_ADD_MEM,  4'hC, 4'h1, 1'b1, 1'b0},
    '{4'h9, 1'b1, OPC_ADD_MEMC, 4'h6, 4'h0, 1'b1, 1'b0},
    '{4'h2, 1'b0, OPC_ADD_MEMC, 4'h3, 4'h5, 1'b0, 1'b0},
    '{4'hF, 1'b0, 10'h061,      4'h0, 4'h0, 1'b0, 1'b0},
    '{4'h3, 1'b1, 10'h062,      4'h0, 4'h5, 1'b1, 1'b1},
    '{4'hC, 1'b0, OPC_AND,      4'hA, 4'h8, 1'b0, 1'b0},
    '{4'hC, 1'b1, OPC_OR,       4'h3, 4'hF, 1'b1, 1'b0},
    '{4'h4, 1'b0, OPC_SET_CY,   4'h0, 4'h4, 1'b1, 1'b0},
    '{4'h4, 1'b1, OPC_CLR_CY,   4'h0, 4'h4, 1'b0, 1'b0},
    '{4'h6, 1'b0, OPC_SKIP_NC,  4'h0, 4'h6, 1'b0, 1'b1},
    '{4'h6, 1'b1, OPC_SKIP_NC,  4'h0, 4'h6, 1'b1, 1'b0},
    '{4'h6, 1'b0, OPC_CMA,      4'h0, 4'h9, 1'b0, 1'b0},
    '{4'h0, 1'b1, 10'h07B,      4'h0, 4'hB, 1'b1, 1'b0}
  };
  accum_datapath #(.PAGE_COUNT(64)) DUT (
    .clk, .rst, .instr_valid, .instr_ready, .instr_code, .skip_next,
    .stack_push, .stack_pop, .pointed_memory_nibble, .rom_req, .rom_page,
    .rom_addr, .rom_valid, .rom_data, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );
  far_side_model far_side (
    .clk, .rst, .rom_req, .rom_page, .rom_addr, .rom_valid, .rom_data,
    .stack_push, .stack_pop, .rom_delay, .depth, .max_depth
  );
  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic results();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results
  // offer one instruction, return at the edge that takes it
  task automatic exec(input logic [9:0] c, input logic [3:0] m);
    instr_valid           <= 1'b1;
    instr_code            <= c;
    pointed_memory_nibble <= m;
    do @(posedge clk); while (!instr_ready);
  endtask : exec
  // one write; the idle edge at the end keeps tasks from overlapping
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d,
                           input logic [3:0] s, output logic [1:0] rs);
    instr_valid   <= 1'b0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      rs = s_axi_bresp;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask : axi_write
  task automatic axi_read(input logic [3:0] a, output logic [31:0] d,
                          output logic [1:0] rs);
    instr_valid   <= 1'b0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      d  = s_axi_rdata;
      rs = s_axi_rresp;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask : axi_read
  task automatic state_is(input string n, input logic [31:0] e,
                          input logic [31:0] m);
    axi_read(ADDR_STATE, st, rsp);
    chk(n, e, st & m);
  endtask : state_is
  // follow a lookup just taken until the core is ready again
  task automatic lookup(input logic [6:0] pg, input logic [6:0] ad);
    instr_valid <= 1'b0;
    @(posedge clk);
    chk("push", 32'h1, 32'(stack_push));
    chk("busy", 32'h0, 32'(instr_ready));
    chk("page", 32'(pg), 32'(rom_page));
    chk("addr", 32'(ad), 32'(rom_addr));
    do @(posedge clk); while (!instr_ready);
    chk("depth", 32'h0, 32'(depth));
    chk("max_depth", 32'h1, 32'(max_depth));
  endtask : lookup
  // ----------------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------------
  initial begin
    rst = 1'b1;
    rom_delay = 0;
    {instr_valid, instr_code, pointed_memory_nibble} = '0;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid} = '0;
    s_axi_rready = 1'b0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    axi_read(ADDR_STATE, st, rsp);
    chk("state_rst", 32'h0, st);
    axi_read(ADDR_CTRL, st, rsp);
    chk("ctrl_rst", 32'h0, st);
    // table of plain cases
    foreach (rows[i]) begin
      r = rows[i];
      exec(10'h000, 4'h0);
      exec({OPC_LOAD_HI, r.a0}, 4'h0);
      exec(r.cy ? OPC_SET_CY : OPC_CLR_CY, 4'h0);
      exec(r.code, r.mem);
      axi_read(ADDR_STATE, st, rsp);
      chk("acc", 32'(r.acc), 32'(st[3:0]));
      chk("carry", 32'(r.cyo), 32'(st[4]));
      chk("skip", 32'(r.skp), 32'(st[16]));
      chk("skip_pin", 32'(r.skp), 32'(skip_next));
    end
    // run of loads, then a skipped complement
    exec(10'h000, 4'h0);
    exec(OPC_SET_CY, 4'h0);
    exec(10'h073, 4'h0);
    exec(10'h077, 4'h0);
    exec(10'h079, 4'h0);
    state_is("loads", 32'h13, 32'h1001F);
    exec(10'h062, 4'h0);
    exec(OPC_CMA, 4'h0);
    state_is("suppressed", 32'h15, 32'h1001F);
    // lookup with the upper flag set, prompt rom
    axi_write(ADDR_CTRL, 32'h1, 4'hF, rsp);
    axi_write(ADDR_TABLE_HIGH, 32'h5, 4'hF, rsp);
    chk("d_resp", 32'(RESP_OKAY), 32'(rsp));
    exec(10'h07A, 4'h0);
    exec({OPC_TABLE_HI, 6'h2A}, 4'h0);
    lookup(7'h2A, 7'h5A);
    state_is("lookup_up", 32'h251B, 32'h37F1F);
    // lookup on the top page, flag clear, slow rom
    axi_write(ADDR_CTRL, 32'h0, 4'hF, rsp);
    rom_delay <= 4;
    exec({OPC_TABLE_HI, 6'h3F}, 4'h0);
    lookup(7'h3F, 7'h2B);
    state_is("lookup_plain", 32'h2415, 32'h37F1F);
    // bus corners: empty strobe, unmapped place
    axi_write(ADDR_TABLE_HIGH, 32'h7, 4'h0, rsp);
    axi_read(ADDR_TABLE_HIGH, st, rsp);
    chk("d_kept", 32'h2, st & 32'h7);
    axi_read(4'hC, st, rsp);
    chk("rd_unmapped", 32'(RESP_SLVERR), 32'(rsp));
    chk("rd_zero", 32'h0, st);
    axi_write(4'hC, 32'hF, 4'hF, rsp);
    chk("wr_unmapped", 32'(RESP_SLVERR), 32'(rsp));
    // reset in mid-run clears acc, carry, b, d and skip
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    state_is("state_rst2", 32'h0, 32'h37F1F);
    chk("skip_rst2", 32'h0, 32'(skip_next));
    results();
  end
  // watchdog against a hang
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    results();
  end
endmodule : accumulator_alu_table_lookup_tb_top
`default_nettype wire

// ==== tb/far_side_model.sv ====
// far_side_model: program rom and stack depth tracker behind the datapath
// assumes: rom_req held until rom_valid, one push and one pop per lookup
`timescale 1ns/1ps
`default_nettype none
module far_side_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       rom_req,
  input  wire logic [6:0] rom_page,
  input  wire logic [6:0] rom_addr,
  output logic            rom_valid,
  output logic      [9:0] rom_data,
  input  wire logic       stack_push,
  input  wire logic       stack_pop,
  input  var  int         rom_delay,
  output int              depth,
  output int              max_depth
);
  // ----------------------------------------------------------------------
  // rom answer
  // ----------------------------------------------------------------------
  int         wait_cnt; // cycles spent on the current request
  logic [9:0] spin;     // junk so a stale word is never mistaken for data
  logic [9:0] word;     // rom content, a fixed mix of page and address
  assign word     = {rom_page[1:0], ~rom_addr[3:0], rom_addr[6:3]};
  assign rom_data = rom_valid ? word : ~spin;
  // answer rom_delay+1 cycles after the request, valid for one cycle only
  always_ff @(posedge clk) begin
    if (rst || !rom_req || rom_valid) begin
      wait_cnt  <= 0;
      rom_valid <= 1'b0;
    end else if (wait_cnt >= rom_delay) begin
      rom_valid <= 1'b1;
    end else begin
      wait_cnt <= wait_cnt + 1;
    end
  end
  // changes every cycle outside an answer
  always_ff @(posedge clk) begin
    spin <= rst ? 10'h000 : spin + 10'h1D3;
  end
  // ----------------------------------------------------------------------
  // stack levels in use
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      depth     <= 0;
      max_depth <= 0;
    end else begin
      depth <= depth + int'(stack_push) - int'(stack_pop);
      if (depth + int'(stack_push) > max_depth) begin
        max_depth <= depth + int'(stack_push);
      end
    end
  end
endmodule : far_side_model
`default_nettype wire
